// >>> verilog/uhpm_ctrl.sv
/*
 * Power management control/status register of a USB enhanced host function.
 * Assumes single-cycle config write/read strobes with byte enables,
 * inputs synchronous to ref_clk_i, and a separate suspend-well reset.
 */
`timescale 1ns/1ps
module uhpm_ctrl (
    // Clock and resets
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        susp_rst_n_i,
    // Configuration access
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [1:0]  cfg_be_i,
    input  wire logic [15:0] cfg_wdata_i,
    output logic [15:0]      cfg_rdata_o,
    output logic             cfg_ack_o,
    // Memory range gate
    input  wire logic        mem_req_i,
    output logic             mem_accept_o,
    // Function events
    input  wire logic        wake_event_i,
    output logic             wake_o,
    output logic             warm_rst_o,
    output logic [1:0]       power_state_o
);
    import uhpm_pkg::*;

    typedef enum logic [1:0] {
        UHPM_RUN  = 2'b01,
        UHPM_WRST = 2'b10
    } uhpm_state_t;

    logic        sel;
    logic        wr_lo;
    logic        wr_hi;
    logic        sts_clr;
    logic        wake_sts;
    logic        wake_en;
    logic [1:0]  pstate_r;
    logic [1:0]  pstate_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic [3:0]  cnt_r;
    logic [3:0]  cnt_nxt;
    uhpm_state_t st_r;
    uhpm_state_t st_nxt;

    function automatic logic [15:0] pack_reg(input logic sts, input logic en,
                                             input logic [1:0] ps);
        logic [15:0] v;
        v = 16'h0000;
        v[WAKE_STS_BIT]      = sts;
        v[POWER_DATA_SCALE_HI:POWER_DATA_SCALE_LO]   = POWER_DATA_SCALE_VALUE;
        v[POWER_DATA_SELECT_HI:POWER_DATA_SELECT_LO]   = POWER_DATA_SELECT_VALUE;
        v[WAKE_EN_BIT]       = en;
        v[PSTATE_HI:PSTATE_LO] = ps;
        return v;
    endfunction

    assign sel     = (cfg_addr_i == PMCS_OFFSET);
    assign wr_lo   = cfg_wr_i && sel && cfg_be_i[0];
    assign wr_hi   = cfg_wr_i && sel && cfg_be_i[1];
    assign sts_clr = wr_hi && cfg_wdata_i[WAKE_STS_BIT];

    uhpm_suspend_bits u_susp (
        .ref_clk_i           (ref_clk_i),
        .susp_rst_n_i        (susp_rst_n_i),
        .wake_event_i        (wake_event_i),
        .sts_clr_i           (sts_clr),
        .en_wr_i             (wr_hi),
        .en_val_i            (cfg_wdata_i[WAKE_EN_BIT]),
        .wake_event_status_o (wake_sts),
        .wake_event_enable_o (wake_en)
    );

    always_comb begin
        pstate_nxt = pstate_r;
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        ack_nxt    = cfg_wr_i || cfg_rd_i;
        rdata_nxt  = rdata_r;
        if (cfg_rd_i) begin
            rdata_nxt = sel ? pack_reg(wake_sts, wake_en, pstate_r) : 16'h0000;
        end
        if (wr_lo) begin
            if (cfg_wdata_i[PSTATE_HI:PSTATE_LO] == PSTATE_D0 ||
                cfg_wdata_i[PSTATE_HI:PSTATE_LO] == PSTATE_D3HOT) begin
                pstate_nxt = cfg_wdata_i[PSTATE_HI:PSTATE_LO];
            end
        end
        case (st_r)
            UHPM_RUN: begin
                if (pstate_r == PSTATE_D3HOT && pstate_nxt == PSTATE_D0) begin
                    st_nxt  = UHPM_WRST;
                    cnt_nxt = WARM_RST_CYCLES;
                end
            end
            UHPM_WRST: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    st_nxt = UHPM_RUN;
                end
            end
            default: begin
                st_nxt  = UHPM_RUN;
                cnt_nxt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pstate_r <= PMCS_RESET[PSTATE_HI:PSTATE_LO];
            rdata_r  <= 16'h0000;
            ack_r    <= 1'b0;
            cnt_r    <= 4'h0;
            st_r     <= UHPM_RUN;
        end else begin
            pstate_r <= pstate_nxt;
            rdata_r  <= rdata_nxt;
            ack_r    <= ack_nxt;
            cnt_r    <= cnt_nxt;
            st_r     <= st_nxt;
        end
    end

    assign cfg_rdata_o   = rdata_r;
    assign cfg_ack_o     = ack_r;
    assign mem_accept_o  = mem_req_i && (pstate_r != PSTATE_D3HOT);
    assign wake_o        = wake_sts && wake_en;
    assign warm_rst_o    = (st_r == UHPM_WRST);
    assign power_state_o = pstate_r;
endmodule

// >>> inc/uhpm_pkg.sv
/*
 * Constants for the USB host power management control/status register.
 * Assumes a byte-addressed configuration space with byte enables.
 */
package uhpm_pkg;
    localparam logic [7:0]  PMCS_OFFSET      = 8'h54;
    localparam int          PMCS_WIDTH       = 16;
    localparam logic [15:0] PMCS_RESET       = 16'h0000;
    localparam int          WAKE_STS_BIT     = 15;
    localparam int          POWER_DATA_SCALE_HI          = 14;
    localparam int          POWER_DATA_SCALE_LO          = 13;
    localparam int          POWER_DATA_SELECT_HI          = 12;
    localparam int          POWER_DATA_SELECT_LO          = 9;
    localparam int          WAKE_EN_BIT      = 8;
    localparam int          PSTATE_HI        = 1;
    localparam int          PSTATE_LO        = 0;
    localparam logic [1:0]  PSTATE_D0        = 2'h0;
    localparam logic [1:0]  PSTATE_D3HOT     = 2'h3;
    localparam logic [1:0]  POWER_DATA_SCALE_VALUE       = 2'h0;
    localparam logic [3:0]  POWER_DATA_SELECT_VALUE       = 4'h0;
    localparam logic [3:0]  WARM_RST_CYCLES  = 4'h4;
endpackage

// >>> verilog/uhpm_suspend_bits.sv
/*
 * Suspend-well wake status and enable bits.
 * Assumes a separate suspend-well reset; core and warm resets do not reach here.
 */
`timescale 1ns/1ps
module uhpm_suspend_bits (
    // Clock and suspend reset
    input  wire logic ref_clk_i,
    input  wire logic susp_rst_n_i,
    // Controls
    input  wire logic wake_event_i,
    input  wire logic sts_clr_i,
    input  wire logic en_wr_i,
    input  wire logic en_val_i,
    // State
    output logic      wake_event_status_o,
    output logic      wake_event_enable_o
);
    import uhpm_pkg::*;

    logic sts_r;
    logic sts_nxt;
    logic en_r;
    logic en_nxt;

    always_comb begin
        sts_nxt = sts_r;
        if (sts_clr_i) begin
            sts_nxt = 1'b0;
        end
        if (wake_event_i) begin
            sts_nxt = 1'b1;
        end
        en_nxt = en_wr_i ? en_val_i : en_r;
    end

    always_ff @(posedge ref_clk_i or negedge susp_rst_n_i) begin
        if (!susp_rst_n_i) begin
            sts_r <= PMCS_RESET[WAKE_STS_BIT];
            en_r  <= PMCS_RESET[WAKE_EN_BIT];
        end else begin
            sts_r <= sts_nxt;
            en_r  <= en_nxt;
        end
    end

    assign wake_event_status_o = sts_r;
    assign wake_event_enable_o = en_r;
endmodule

// >>> testbench/uhpm_ctrl_monitor.sv
/* Port checker for uhpm_ctrl.
   Assumes both resets are released together. */
`timescale 1ns/1ps
module uhpm_ctrl_monitor (
    input wire logic        ref_clk_i, rst_n_i, cfg_wr_i, cfg_rd_i, cfg_ack_o,
    input wire logic        mem_req_i, mem_accept_o, wake_event_i, wake_o, warm_rst_o,
    input wire logic [7:0]  cfg_addr_i,
    input wire logic [1:0]  cfg_be_i, power_state_o,
    input wire logic [15:0] cfg_wdata_i, cfg_rdata_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic lo_wr, hi_wr;
    assign lo_wr = cfg_wr_i && cfg_be_i[0] && cfg_addr_i == 8'h54;
    assign hi_wr = cfg_wr_i && cfg_be_i[1] && cfg_addr_i == 8'h54;
    AST_ACK: assert property (cfg_wr_i || cfg_rd_i |=> cfg_ack_o) else $error("ack");
    AST_PS_SET: assert property (lo_wr && cfg_wdata_i[1:0] == 2'h3 |=> power_state_o == 2'h3)
        else $error("ps");
    AST_PS_KEEP: assert property (lo_wr && ^cfg_wdata_i[1:0] |=> $stable(power_state_o))
        else $error("ps kept");
    AST_WARM: assert property (lo_wr && cfg_wdata_i[1:0] == 2'h0 && power_state_o == 2'h3
        |=> warm_rst_o [*4] ##1 !warm_rst_o) else $error("warm");
    AST_MEM: assert property (mem_accept_o == (mem_req_i && power_state_o != 2'h3))
        else $error("mem");
    AST_W1C: assert property (hi_wr && cfg_wdata_i[15] && !wake_event_i |=> !wake_o)
        else $error("w1c");
    AST_HOLD: assert property (wake_o && !cfg_wr_i |=> wake_o) else $error("wake");
    AST_RO: assert property ((cfg_rdata_o & 16'h7efc) == 16'h0) else $error("ro");
    cover property (warm_rst_o);
    cover property (wake_o);
    cover property (mem_req_i && !mem_accept_o);
endmodule
bind uhpm_ctrl uhpm_ctrl_monitor u_mon (.*);

// >>> testbench/uhpm_host_model.sv
/* Host software config access model.
   Assumes one-cycle strobes and ack one cycle later. */
`timescale 1ns/1ps
module uhpm_host_model (
    input  wire logic        ref_clk_i, cfg_ack_i,
    input  wire logic [15:0] cfg_rdata_i,
    output logic             cfg_wr_o, cfg_rd_o,
    output logic [7:0]       cfg_addr_o,
    output logic [1:0]       cfg_be_o,
    output logic [15:0]      cfg_wdata_o
);
    initial {cfg_wr_o, cfg_rd_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [1:0] b,
                        input logic [15:0] v, output logic [15:0] q, output logic k);
        @(negedge ref_clk_i);
        {cfg_wr_o, cfg_rd_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = {w, !w, a, b, v};
        @(negedge ref_clk_i);
        k = cfg_ack_i;
        q = cfg_rdata_i;
        {cfg_wr_o, cfg_rd_o, cfg_addr_o, cfg_wdata_o} = {2'h0, ~a, ~v};
    endtask
endmodule

// >>> testbench/tb_top.sv
/* Testbench for uhpm_ctrl.
   Assumes the host model drives config and the checker is bound. */
`timescale 1ns/1ps
module tb_top;
    import uhpm_pkg::*;
    logic ref_clk_i = 0, rst_n_i = 0, susp_rst_n_i = 0, mem_req_i = 0, wake_event_i = 0;
    logic cfg_wr_i, cfg_rd_i, cfg_ack_o, mem_accept_o, wake_o, warm_rst_o, k;
    logic [7:0]  cfg_addr_i;
    logic [1:0]  cfg_be_i, power_state_o, ps;
    logic [15:0] cfg_wdata_i, cfg_rdata_o, q, d;
    int num_errors = 0, samples_checked = 0;
    always #20 ref_clk_i = ~ref_clk_i;
    uhpm_ctrl uut (.*);
    uhpm_host_model host (.ref_clk_i, .cfg_ack_i(cfg_ack_o), .cfg_rdata_i(cfg_rdata_o),
        .cfg_wr_o(cfg_wr_i), .cfg_rd_o(cfg_rd_i), .cfg_addr_o(cfg_addr_i),
        .cfg_be_o(cfg_be_i), .cfg_wdata_o(cfg_wdata_i));
    function automatic logic [15:0] exp_reg(logic s, logic e, logic [1:0] p);
        return {s, 6'h0, e, 6'h0, p};
    endfunction
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(logic [1:0] be, logic [15:0] v);
        host.xfer(1'b1, PMCS_OFFSET, be, v, q, k);
        chk(k, 1);
    endtask
    task automatic rd(logic [7:0] a, logic [15:0] exp);
        host.xfer(1'b0, a, 2'h3, 16'h0, q, k);
        chk(q, exp);
    endtask
    task automatic end_of_test;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        num_errors++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'hb1e7d3a2));
        repeat (10) @(negedge ref_clk_i);
        {rst_n_i, susp_rst_n_i} = 2'h3;
        rd(PMCS_OFFSET, 16'h0);
        wr(2'h3, 16'h8000);
        ps = 2'h0;
        for (int i = 0; i < 12; i++) begin
            d = $urandom;
            if (i < 4) d[1:0] = 2'h3 - i[1:0];
            wr(2'h1, d);
            chk(warm_rst_o, ps == 2'h3 && d[1:0] == 2'h0);
            if (!(^d[1:0])) ps = d[1:0];
            chk(power_state_o, ps);
            mem_req_i = d[15];
            #1 chk(mem_accept_o, d[15] && ps != 2'h3);
            rd(PMCS_OFFSET, exp_reg(0, 0, ps));
        end
        $display("power state test done");
        wr(2'h1, 16'h0);
        chk(power_state_o, PSTATE_D0);
        wake_event_i = 1;
        @(negedge ref_clk_i) wake_event_i = 0;
        rd(PMCS_OFFSET, exp_reg(1, 0, 0));
        chk(wake_o, 0);
        wr(2'h2, 16'h0100);
        chk(wake_o, 1);
        rst_n_i = 0;
        @(negedge ref_clk_i) rst_n_i = 1;
        chk(power_state_o, PSTATE_D0);
        wr(2'h1, 16'h0003);
        wr(2'h1, 16'h0000);
        rd(PMCS_OFFSET, exp_reg(1, 1, 0));
        wr(2'h2, 16'h0100);
        chk(wake_o, 1);
        wr(2'h2, 16'h8100);
        chk(wake_o, 0);
        rd(8'h56, 16'h0);
        $display("wake test done");
        end_of_test;
    end
endmodule
